// ===== common/sar_adc_pkg.sv
// Package: register addresses, field positions, reset values and states
// Assumes an 8-bit special function register port and one system clock
package sar_adc_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] ADDR_PAIR_CONFIG = 8'hba;
  localparam logic [7:0] ADDR_CHANNEL_SEL = 8'hbb;
  localparam logic [7:0] ADDR_CONFIG = 8'hbc;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'hbe;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'hbf;
  localparam logic [7:0] ADDR_CONTROL = 8'he8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_PAIR_CONFIG = 8'h00;
  localparam logic [7:0] RST_CHANNEL_SEL = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'hf8;
  localparam logic [7:0] RST_CONTROL = 8'h00;

  // ****************************************
  // Control register bits
  // ****************************************
  localparam int CTL_ENABLE = 7;
  localparam int CTL_TRACK_LP = 6;
  localparam int CTL_DONE = 5;
  localparam int CTL_BUSY = 4;
  localparam int CTL_MODE_HI = 3;
  localparam int CTL_MODE_LO = 2;
  localparam int CTL_WINDOW = 1;
  localparam int CTL_LJUST = 0;

  // ****************************************
  // Config and channel fields
  // ****************************************
  localparam int CFG_DIV_LSB = 3;
  localparam int CFG_GAIN_LSB = 0;
  localparam int PAIR_BITS = 4;
  localparam int CHAN_BITS = 4;
  localparam int CHAN_TEMP_BIT = 3;
  localparam logic [2:0] GAIN_UNITY = 3'h0;

  // ****************************************
  // Start modes and timing
  // ****************************************
  localparam logic [1:0] START_SOFTWARE = 2'h0;
  localparam logic [1:0] START_TIMER3 = 2'h1;
  localparam logic [1:0] START_STROBE = 2'h2;
  localparam logic [1:0] START_TIMER2 = 2'h3;
  localparam int TRACK_SAR_CLOCKS = 3;
  localparam int CONV_SAR_CLOCKS = 16;
  localparam int MAX_RATE_KSPS = 100;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_TRACK = 4'b0010,
    ST_CONVERT = 4'b0100,
    ST_FINISH = 4'b1000
  } conv_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
  } sfr_req_t;

  typedef struct packed {
    logic power_on;
    logic track;
    logic sample;
    logic [3:0] channel;
    logic [2:0] gain;
    logic [3:0] pair_diff;
  } analog_ctl_t;

endpackage

// ===== design/sar_clock_divider.sv
// SAR clock enable generator dividing the system clock
// Assumes divide value is a 5-bit field; tick period is value+1 clocks
`timescale 1ns/1ns
module sar_clock_divider
  import sar_adc_pkg::*;
#(
  parameter int DIV_WIDTH = 5
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [DIV_WIDTH-1:0] divide,
  output logic sar_tick
);

  logic [DIV_WIDTH-1:0] count_reg;
  logic [DIV_WIDTH-1:0] count_next;
  logic tick_next;
  logic tick_reg;

  always_comb
  begin
    count_next = count_reg;
    tick_next = 1'b0;
    if (!run)
    begin
      count_next = '0;
    end
    else if (count_reg >= divide)
    begin
      count_next = '0;
      tick_next = 1'b1;
    end
    else
    begin
      count_next = count_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      count_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      tick_reg <= tick_next;
    end
  end

  assign sar_tick = tick_reg;

endmodule

// ===== design/sar_adc_control.sv
// Conversion control for the successive-approximation converter
// Assumes an 8-bit special function register port and a SAR core that
// returns a 12-bit result when told to sample over the conversion period
`timescale 1ns/1ns
// What this block does
// (R1) The SAR clock is the system clock divided by the config divider field plus one, for up to 100 ksps.
// (R2) A conversion starts on a busy write, a timer 3 overflow, a strobe rising edge or a timer 2 overflow.
// (R3) Start mode 00 is busy write, 01 timer 3, 10 strobe rising edge, 11 timer 2.
// (R4) The busy bit stays one for the whole conversion and drops to zero when it completes.
// (R5) The falling edge of busy sets the done flag at control bit 5 and raises the interrupt when enabled.
// (R6) Each result goes to the high and low registers, left or right justified by the justify bit.
// (R7) Software should clear done, write busy, poll done, then read the result.
// (R8) With low-power tracking off, the input is tracked whenever no conversion runs.
// (R9) With low-power tracking on, three SAR clocks of tracking follow each start other than a strobe start before conversion.
// (R10) In low-power tracking with strobe start, tracking happens only while the strobe is low.
// (R11) Tracking is shut off while the chip is in standby or sleep.
// (R12) Selecting the temperature sensor routes it into the gain amplifier at the programmed gain.
// (R13) Pair bits 0 to 3 make input pairs single-ended when zero or differential, even input positive, when one.
// (R14) Differential results are two's complement, single-ended results unsigned.
// (R15) Converter, track-and-hold and amplifier are powered only while the enable bit is one.
// (R16) After reset all inputs are single-ended and the gain is unity.
module sar_adc_control
  import sar_adc_pkg::*;
#(
  parameter int RESULT_BITS = 12
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic timer3_overflow,
  input wire logic timer2_overflow,
  input wire logic ext_convert_strobe,
  input wire logic chip_sleep,
  input wire logic [RESULT_BITS-1:0] sar_result,
  input wire logic adc_int_enable,
  output analog_ctl_t analog_ctl,
  output logic temp_sensor_sel,
  output logic conv_done_irq
);

  // ****************************************
  // Registers and state
  // ****************************************
  logic [7:0] control_reg;
  logic [7:0] control_next;
  logic [7:0] config_reg;
  logic [7:0] config_next;
  logic [CHAN_BITS-1:0] channel_sel_reg;
  logic [CHAN_BITS-1:0] channel_sel_next;
  logic [PAIR_BITS-1:0] pair_cfg_reg;
  logic [PAIR_BITS-1:0] pair_cfg_next;
  logic [7:0] result_high_reg;
  logic [7:0] result_high_next;
  logic [7:0] result_low_reg;
  logic [7:0] result_low_next;
  conv_state_t state_reg;
  conv_state_t state_next;
  logic [4:0] sar_count_reg;
  logic [4:0] sar_count_next;
  logic busy_prev_reg;
  logic [2:0] strobe_sync_reg;
  logic strobe_level_reg;
  logic strobe_level_next;
  logic sar_tick;
  logic start_event;
  logic strobe_rise;
  logic busy_write;
  logic diff_channel;
  logic [RESULT_BITS-1:0] conv_value;
  logic [15:0] placed;
  logic conv_active;
  logic track_now;

  // Is the selected channel part of a differential pair
  function automatic logic is_diff(input logic [3:0] chan, input logic [3:0] pairs);
    logic d;
    d = 1'b0;
    if (!chan[CHAN_TEMP_BIT])
    begin
      d = pairs[chan[2:1]];
    end
    return d;
  endfunction

  // ****************************************
  // Strobe synchroniser
  // ****************************************
  always_comb
  begin
    strobe_level_next = strobe_level_reg;
    if (strobe_sync_reg[1] == strobe_sync_reg[2])
    begin
      strobe_level_next = strobe_sync_reg[2];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      strobe_sync_reg <= 3'h0;
      strobe_level_reg <= 1'b0;
    end
    else
    begin
      strobe_sync_reg <= {strobe_sync_reg[1:0], ext_convert_strobe};
      strobe_level_reg <= strobe_level_next;
    end
  end

  assign strobe_rise = strobe_level_next & ~strobe_level_reg;

  // (R1) SAR clock divide
  sar_clock_divider #(
    .DIV_WIDTH(5)
  ) u_divider (
    .sys_clk(sys_clk),
    .reset(reset),
    .run(conv_active),
    .divide(config_reg[7:CFG_DIV_LSB]),
    .sar_tick(sar_tick)
  );

  // ****************************************
  // Start selection
  // ****************************************
  assign busy_write = sfr_req.wr && sfr_req.addr == ADDR_CONTROL && sfr_req.wdata[CTL_BUSY];

  always_comb
  begin
    // (R2) Start source select
    // (R3) Mode encoding
    case (control_reg[CTL_MODE_HI:CTL_MODE_LO])
      START_SOFTWARE: start_event = busy_write;
      START_TIMER3: start_event = timer3_overflow;
      START_STROBE: start_event = strobe_rise;
      default: start_event = timer2_overflow;
    endcase
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    sar_count_next = sar_count_reg;
    case (state_reg)
      ST_IDLE:
      begin
        // (R15) Start only when powered
        if (start_event && control_reg[CTL_ENABLE])
        begin
          sar_count_next = 5'h0;
          // (R9) Low-power tracking first
          if (control_reg[CTL_TRACK_LP] && control_reg[CTL_MODE_HI:CTL_MODE_LO] != START_STROBE)
          begin
            state_next = ST_TRACK;
          end
          else
          begin
            state_next = ST_CONVERT;
          end
        end
      end
      ST_TRACK:
      begin
        if (sar_tick)
        begin
          if (sar_count_reg == 5'(TRACK_SAR_CLOCKS - 1))
          begin
            sar_count_next = 5'h0;
            state_next = ST_CONVERT;
          end
          else
          begin
            sar_count_next = sar_count_reg + 5'h1;
          end
        end
      end
      ST_CONVERT:
      begin
        if (sar_tick)
        begin
          if (sar_count_reg == 5'(CONV_SAR_CLOCKS - 1))
          begin
            state_next = ST_FINISH;
          end
          else
          begin
            sar_count_next = sar_count_reg + 5'h1;
          end
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
    if (!control_reg[CTL_ENABLE])
    begin
      state_next = ST_IDLE;
    end
  end

  assign conv_active = state_reg == ST_TRACK || state_reg == ST_CONVERT;

  // ****************************************
  // Result placement
  // ****************************************
  always_comb
  begin
    diff_channel = is_diff(channel_sel_reg, pair_cfg_reg);
    // (R14) Signed for differential
    conv_value = diff_channel ? (sar_result ^ {1'b1, {(RESULT_BITS-1){1'b0}}}) : sar_result;
    // (R6) Justification
    if (control_reg[CTL_LJUST])
    begin
      placed = {conv_value, {(16-RESULT_BITS){1'b0}}};
    end
    else
    begin
      placed = {{(16-RESULT_BITS){diff_channel & conv_value[RESULT_BITS-1]}}, conv_value};
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always_comb
  begin
    control_next = control_reg;
    config_next = config_reg;
    channel_sel_next = channel_sel_reg;
    pair_cfg_next = pair_cfg_reg;
    result_high_next = result_high_reg;
    result_low_next = result_low_reg;
    if (sfr_req.wr)
    begin
      if (sfr_req.addr == ADDR_CONTROL)
      begin
        control_next = sfr_req.wdata;
        control_next[CTL_BUSY] = control_reg[CTL_BUSY];
      end
      else if (sfr_req.addr == ADDR_CONFIG)
      begin
        config_next = sfr_req.wdata;
      end
      else if (sfr_req.addr == ADDR_CHANNEL_SEL)
      begin
        channel_sel_next = sfr_req.wdata[CHAN_BITS-1:0];
      end
      else if (sfr_req.addr == ADDR_PAIR_CONFIG)
      begin
        // (R13) Pair configuration
        pair_cfg_next = sfr_req.wdata[PAIR_BITS-1:0];
      end
    end
    // (R4) Busy follows the sequencer
    control_next[CTL_BUSY] = state_next != ST_IDLE;
    if (state_reg == ST_FINISH)
    begin
      result_high_next = placed[15:8];
      result_low_next = placed[7:0];
    end
    // (R5) Done set on busy fall, set wins
    if (busy_prev_reg && !control_reg[CTL_BUSY])
    begin
      control_next[CTL_DONE] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      control_reg <= RST_CONTROL;
      // (R16) Unity gain and single-ended
      config_reg <= RST_CONFIG;
      channel_sel_reg <= RST_CHANNEL_SEL[CHAN_BITS-1:0];
      pair_cfg_reg <= RST_PAIR_CONFIG[PAIR_BITS-1:0];
      result_high_reg <= 8'h00;
      result_low_reg <= 8'h00;
      state_reg <= ST_IDLE;
      sar_count_reg <= 5'h0;
      busy_prev_reg <= 1'b0;
    end
    else
    begin
      control_reg <= control_next;
      config_reg <= config_next;
      channel_sel_reg <= channel_sel_next;
      pair_cfg_reg <= pair_cfg_next;
      result_high_reg <= result_high_next;
      result_low_reg <= result_low_next;
      state_reg <= state_next;
      sar_count_reg <= sar_count_next;
      busy_prev_reg <= control_reg[CTL_BUSY];
    end
  end

  // ****************************************
  // Read data and analog controls
  // ****************************************
  always_comb
  begin
    sfr_rdata = 8'h00;
    if (sfr_req.addr == ADDR_CONTROL)
    begin
      sfr_rdata = control_reg;
    end
    else if (sfr_req.addr == ADDR_CONFIG)
    begin
      sfr_rdata = config_reg;
    end
    else if (sfr_req.addr == ADDR_CHANNEL_SEL)
    begin
      sfr_rdata = {4'h0, channel_sel_reg};
    end
    else if (sfr_req.addr == ADDR_PAIR_CONFIG)
    begin
      sfr_rdata = {4'h0, pair_cfg_reg};
    end
    else if (sfr_req.addr == ADDR_RESULT_HIGH)
    begin
      sfr_rdata = result_high_reg;
    end
    else if (sfr_req.addr == ADDR_RESULT_LOW)
    begin
      sfr_rdata = result_low_reg;
    end
  end

  always_comb
  begin
    if (!control_reg[CTL_TRACK_LP])
    begin
      // (R8) Continuous tracking
      track_now = state_reg == ST_IDLE;
    end
    else if (control_reg[CTL_MODE_HI:CTL_MODE_LO] == START_STROBE)
    begin
      // (R10) Track while strobe low
      track_now = state_reg == ST_IDLE && !strobe_level_reg;
    end
    else
    begin
      track_now = state_reg == ST_TRACK;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      analog_ctl <= '0;
      temp_sensor_sel <= 1'b0;
      conv_done_irq <= 1'b0;
    end
    else
    begin
      // (R15) Power gating
      analog_ctl.power_on <= control_reg[CTL_ENABLE];
      // (R11) Sleep stops tracking
      analog_ctl.track <= track_now && control_reg[CTL_ENABLE] && !chip_sleep;
      analog_ctl.sample <= state_reg == ST_CONVERT;
      analog_ctl.channel <= channel_sel_reg;
      analog_ctl.gain <= config_reg[2:CFG_GAIN_LSB];
      analog_ctl.pair_diff <= pair_cfg_reg;
      // (R12) Temperature sensor to amplifier
      temp_sensor_sel <= channel_sel_reg[CHAN_TEMP_BIT];
      // (R5) Interrupt when enabled
      conv_done_irq <= control_reg[CTL_DONE] && adc_int_enable;
    end
  end

endmodule

// ===== tb/sar_adc_control_sva.sv
// Port checker for the conversion control
// Assumes it is bound into sar_adc_control
`timescale 1ns/1ns
module sar_adc_control_sva
  import sar_adc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic chip_sleep,
  input wire logic adc_int_enable,
  input wire analog_ctl_t analog_ctl,
  input wire logic temp_sensor_sel,
  input wire logic conv_done_irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  logic mapped;
  assign mapped = sfr_req.addr inside {ADDR_PAIR_CONFIG, ADDR_CHANNEL_SEL, ADDR_CONFIG,
    ADDR_RESULT_LOW, ADDR_RESULT_HIGH, ADDR_CONTROL};
  // ****************************************
  // Properties
  // ****************************************
  a_reset_quiet: assert property ($fell(reset) |-> analog_ctl == '0 && !conv_done_irq)
    else $error("outputs busy after reset");
  a_irq_gated: assert property (!adc_int_enable |=> !conv_done_irq)
    else $error("irq while disabled");
  a_irq_cause: assert property ($rose(conv_done_irq) |-> $past(adc_int_enable))
    else $error("irq rose without enable");
  a_temp_mirror: assert property (temp_sensor_sel == analog_ctl.channel[CHAN_TEMP_BIT])
    else $error("temp select differs from channel");
  a_sleep_track: assert property (chip_sleep |=> !analog_ctl.track)
    else $error("tracking in sleep");
  a_unpowered_idle: assert property (!analog_ctl.power_on && !$past(analog_ctl.power_on)
    |-> !analog_ctl.sample)
    else $error("sampling while unpowered");
  a_pair_readback: assert property (sfr_req.wr && sfr_req.addr == ADDR_PAIR_CONFIG
    ##1 sfr_req.addr == ADDR_PAIR_CONFIG |-> sfr_rdata[3:0] == $past(sfr_req.wdata[3:0]))
    else $error("pair config readback wrong");
  a_pair_upper: assert property (sfr_req.addr == ADDR_PAIR_CONFIG |-> sfr_rdata[7:4] == 4'h0)
    else $error("pair config upper bits set");
  a_unmapped_zero: assert property (!mapped |-> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind sar_adc_control sar_adc_control_sva chk_u (.sys_clk(sys_clk), .reset(reset), .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata), .chip_sleep(chip_sleep), .adc_int_enable(adc_int_enable),
  .analog_ctl(analog_ctl), .temp_sensor_sel(temp_sensor_sel), .conv_done_irq(conv_done_irq));

// ===== tb/sar_core_model.sv
// SAR core stand-in returning a fixed offset-binary code while powered and its bitwise complement when not
// Assumes the bench picks the code
`timescale 1ns/1ns
module sar_core_model
  import sar_adc_pkg::*;
(
  input wire analog_ctl_t ctl,
  input wire logic [11:0] code,
  output logic [11:0] sar_result
);
  assign sar_result = ctl.power_on ? code : ~code;
endmodule

// ===== tb/sar_adc_control_test.sv
// Bench for the conversion control
// Assumes a 100 MHz clock and the core stand-in
`timescale 1ns/1ns
module sar_adc_control_test
  import sar_adc_pkg::*;
;
  logic sys_clk;
  logic reset;
  logic t3;
  logic t2;
  logic strobe;
  logic sleep;
  logic irq_en;
  logic temp_sel;
  logic irq;
  logic [7:0] rdata;
  logic [11:0] res;
  logic [11:0] code;
  sfr_req_t req;
  analog_ctl_t actl;
  int bad_count;
  int total_checks;

  sar_adc_control dut_u (.sys_clk(sys_clk), .reset(reset), .sfr_req(req), .sfr_rdata(rdata),
    .timer3_overflow(t3), .timer2_overflow(t2), .ext_convert_strobe(strobe), .chip_sleep(sleep),
    .sar_result(res), .adc_int_enable(irq_en), .analog_ctl(actl), .temp_sensor_sel(temp_sel),
    .conv_done_irq(irq));
  sar_core_model core_u (.ctl(actl), .code(code), .sar_result(res));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic conclude();
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= {a, d, 1'b1};
    @(posedge sys_clk);
    req <= {a, d, 1'b0};
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    req <= {a, 8'h00, 1'b0};
    #1;
    d = rdata;
  endtask

  task automatic conv(input logic [7:0] ctl, output int n);
    logic [7:0] v;
    wr(ADDR_CONTROL, ctl);
    @(posedge sys_clk);
    case (ctl[3:2])
      START_TIMER3: t3 <= 1'b1;
      START_TIMER2: t2 <= 1'b1;
      START_STROBE: strobe <= 1'b1;
      default: req <= {ADDR_CONTROL, ctl | 8'h10, 1'b1};
    endcase
    @(posedge sys_clk);
    t3 <= 1'b0;
    t2 <= 1'b0;
    req.wr <= 1'b0;
    rd(ADDR_CONTROL, v);
    if (ctl[3:2] == START_SOFTWARE)
    begin
      chk("busy", 8'h01, {7'h0, v[CTL_BUSY]});
      chk("sample", {7'h0, !ctl[CTL_TRACK_LP]}, {7'h0, actl.sample});
    end
    n = 0;
    while (v[CTL_DONE] !== 1'b1 && n < 600)
    begin
      rd(ADDR_CONTROL, v);
      n++;
    end
    chk("done", 8'h01, {7'h0, v[CTL_DONE]});
    chk("idle", 8'h00, {7'h0, v[CTL_BUSY]});
    if (ctl[CTL_TRACK_LP] && ctl[3:2] == START_STROBE)
      chk("strobe hold", 8'h00, {7'h0, actl.track});
    @(posedge sys_clk);
    strobe <= 1'b0;
    if (n >= 600)
      conclude();
  endtask

  task automatic t_regs();
    logic [7:0] v;
    rd(ADDR_CONFIG, v);
    chk("config", RST_CONFIG, v);
    chk("gain", {5'h0, GAIN_UNITY}, {5'h0, actl.gain});
    rd(ADDR_PAIR_CONFIG, v);
    chk("pairs", RST_PAIR_CONFIG, v);
    rd(ADDR_CONTROL, v);
    chk("control", RST_CONTROL, v);
    chk("power", 8'h00, {7'h0, actl.power_on});
    rd(8'hbd, v);
    chk("unmapped", 8'h00, v);
    wr(ADDR_PAIR_CONFIG, 8'hff);
    rd(ADDR_PAIR_CONFIG, v);
    chk("pair rd", 8'h0f, v);
    chk("pair out", 8'h0f, {4'h0, actl.pair_diff});
  endtask

  task automatic t_results();
    logic [7:0] hi;
    logic [7:0] lo;
    logic [11:0] r;
    int n;
    wr(ADDR_CONFIG, 8'h0a);
    rd(ADDR_CONFIG, hi);
    chk("config rd", 8'h0a, hi);
    chk("gain", 8'h02, {5'h0, actl.gain});
    for (int k = 0; k < 4; k++)
    begin
      wr(ADDR_PAIR_CONFIG, {7'h0, k[1]});
      conv({7'h40, k[0]}, n);
      rd(ADDR_RESULT_HIGH, hi);
      rd(ADDR_RESULT_LOW, lo);
      r = k[1] ? code ^ 12'h800 : code;
      chk("high", k[0] ? r[11:4] : {{4{k[1] & r[11]}}, r[11:8]}, hi);
      chk("low", k[0] ? {r[3:0], 4'h0} : r[7:0], lo);
    end
    wr(ADDR_CHANNEL_SEL, 8'h08);
    rd(ADDR_CHANNEL_SEL, hi);
    chk("chan rd", 8'h08, hi);
    chk("chan out", 8'h08, {4'h0, actl.channel});
    chk("temp sel", 8'h01, {7'h0, temp_sel});
  endtask

  task automatic t_lowpower();
    int c0;
    int c1;
    conv(8'h80, c0);
    conv(8'hc0, c1);
    chk("track span", 8'h06, 8'(c1 - c0));
  endtask

  task automatic t_modes();
    logic [7:0] v;
    int n;
    wr(ADDR_CONTROL, 8'h80);
    @(posedge sys_clk);
    t3 <= 1'b1;
    @(posedge sys_clk);
    t3 <= 1'b0;
    rd(ADDR_CONTROL, v);
    rd(ADDR_CONTROL, v);
    chk("no start", 8'h00, {7'h0, v[CTL_BUSY]});
    conv(8'h84, n);
    conv(8'h8c, n);
    wr(ADDR_CONTROL, 8'hc8);
    rd(ADDR_CONTROL, v);
    rd(ADDR_CONTROL, v);
    chk("strobe track", 8'h01, {7'h0, actl.track});
    conv(8'hc8, n);
  endtask

  task automatic t_track_irq();
    logic [7:0] v;
    int n;
    wr(ADDR_CONTROL, 8'h80);
    rd(ADDR_CONTROL, v);
    rd(ADDR_CONTROL, v);
    chk("track idle", 8'h01, {7'h0, actl.track});
    chk("power on", 8'h01, {7'h0, actl.power_on});
    @(posedge sys_clk);
    sleep <= 1'b1;
    irq_en <= 1'b1;
    rd(ADDR_CONTROL, v);
    rd(ADDR_CONTROL, v);
    chk("sleep track", 8'h00, {7'h0, actl.track});
    conv(8'h80, n);
    rd(ADDR_CONTROL, v);
    rd(ADDR_CONTROL, v);
    chk("irq", 8'h01, {7'h0, irq});
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_CONTROL, v);
    rd(ADDR_CONTROL, v);
    chk("irq clear", 8'h00, {7'h0, irq});
    chk("power off", 8'h00, {7'h0, actl.power_on});
  endtask

  initial
  begin
    reset = 1'b1;
    req = '0;
    t3 = 1'b0;
    t2 = 1'b0;
    strobe = 1'b0;
    sleep = 1'b0;
    irq_en = 1'b0;
    code = 12'h5a3;
    bad_count = 0;
    total_checks = 0;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs();
    t_results();
    t_lowpower();
    t_modes();
    t_track_irq();
    conclude();
  end
endmodule
